/* shared/sat_pkg.sv */
package sat_pkg;

  // ************************************************************
  // Register addresses on the special function register bus
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

  // ************************************************************
  // Control register bit positions
  // ************************************************************
  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_EXT_CLK = 0;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_RELOAD = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] RESET_RDATA = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV12_RESET = 4'h0;

endpackage

/* shared/sat_tick_if.sv */
`timescale 1ns/1ps
interface sat_tick_if;
  logic tick_div12;
  logic tick_ext;
  logic lfo_fall;

  modport gen (
    output tick_div12,
    output tick_ext,
    output lfo_fall
  );

  modport use_side (
    input tick_div12,
    input tick_ext,
    input lfo_fall
  );
endinterface

/* design/sat_tick_gen.sv */
`timescale 1ns/1ps
module sat_tick_gen
  import sat_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_clk_div8,
  input wire logic lfo_out,
  sat_tick_if.gen ticks
);

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_d;
    logic lfo_s1;
    logic lfo_s2;
    logic lfo_d;
    logic [3:0] div_cnt;
    logic tick_div12;
    logic tick_ext;
    logic lfo_fall;
  } sat_tick_state_t;

  sat_tick_state_t st_r;
  sat_tick_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // Two stages before anything looks at the pins
    st_nxt.ext_s1 = ext_clk_div8; // [R8]
    st_nxt.ext_s2 = st_r.ext_s1; // [R8]
    st_nxt.ext_d = st_r.ext_s2;
    st_nxt.lfo_s1 = lfo_out;
    st_nxt.lfo_s2 = st_r.lfo_s1;
    st_nxt.lfo_d = st_r.lfo_s2;
    st_nxt.tick_ext = st_r.ext_s2 & ~st_r.ext_d; // [R8]
    st_nxt.lfo_fall = ~st_r.lfo_s2 & st_r.lfo_d;
    if (st_r.div_cnt == DIV12_LAST)
    begin
      st_nxt.div_cnt = DIV12_RESET; // [R7]
    end
    else
    begin
      st_nxt.div_cnt = st_r.div_cnt + 4'h1;
    end
    st_nxt.tick_div12 = (st_r.div_cnt == DIV12_LAST); // [R7]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ticks.tick_div12 = st_r.tick_div12;
  assign ticks.tick_ext = st_r.tick_ext;
  assign ticks.lfo_fall = st_r.lfo_fall;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_quiet11;
    !st_r.tick_div12 [*8] ##1 !st_r.tick_div12 [*3];
  endsequence

  a_div12_period: assert property ( // [R7]
    @(posedge clk) disable iff (!resetn)
    st_r.tick_div12 |=> s_quiet11 ##1 st_r.tick_div12)
    else $error("divide-by-12 tick spacing wrong");

  a_ext_sync_edge: assert property ( // [R8]
    @(posedge clk) disable iff (!resetn)
    $rose(st_r.ext_s2) |=> st_r.tick_ext ##1 !st_r.tick_ext)
    else $error("external tick not one pulse per synced rise");

endmodule

/* design/sat_timer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Split bit picks one 16-bit or two 8-bit
// R2 - 16-bit wrap loads reload pair, sets high flag
// R3 - Interrupt on every 16-bit overflow when enabled
// R4 - Low byte wrap interrupts when low enable set
// R5 - Split bytes reload from own reload registers
// R6 - Run gates only high byte in split mode
// R7 - Per-byte clock: system, div12 or ext/8
// R8 - External div8 clock synchronised before use
// R9 - Split mode sets flag per byte wrap
// R10 - Split interrupts on high, low when enabled
// R11 - Flags cleared only by software writes
// R12 - Oscillator falling edge captures count into reload (code captures only while TIMER_IRQ_ENABLE is high)
// R13 - Count advances one per enabled tick
module sat_timer
  import sat_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire logic EXT_CLK_DIV8,
  input wire logic LFO_OUT,
  input wire logic HIGH_BYTE_CLOCK_SELECT,
  input wire logic LOW_BYTE_CLOCK_SELECT,
  input wire logic TIMER_IRQ_ENABLE,
  output logic IRQ
);

  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic lfo_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic external_clock_select;
    logic capture_pend;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] rdata;
  } sat_state_t;

  sat_state_t st_r;
  sat_state_t st_nxt;

  sat_tick_if ticks ();

  sat_tick_gen u_ticks (
    .clk(CLK),
    .resetn(RESETN),
    .ext_clk_div8(EXT_CLK_DIV8),
    .lfo_out(LFO_OUT),
    .ticks(ticks)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  // Bit 8 is the wrap, bits 7..0 the next byte value
  function automatic logic [8:0] bump8(input logic [7:0] v,
                                       input logic [7:0] rl);
    bump8 = (v == BYTE_MAX) ? {1'b1, rl} : {1'b0, v + 8'h01};
  endfunction

  function automatic logic pick_tick(input logic system_clock_sel,
                                     input logic ext_sel,
                                     input logic t_div12,
                                     input logic t_ext);
    pick_tick = system_clock_sel | (ext_sel ? t_ext : t_div12);
  endfunction

  logic tick_l;
  logic tick_h;
  logic wr_ctl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cl;
  logic wr_ch;
  logic capture;
  logic [8:0] low_step;
  logic [8:0] high_step;
  logic [8:0] low_chain;
  logic set_h;
  logic set_l;
  logic [7:0] ctl_view;

  always_comb
  begin
    tick_l = pick_tick(LOW_BYTE_CLOCK_SELECT, st_r.external_clock_select,
                       ticks.tick_div12, ticks.tick_ext); // [R7]
    tick_h = pick_tick(HIGH_BYTE_CLOCK_SELECT, st_r.external_clock_select,
                       ticks.tick_div12, ticks.tick_ext); // [R7]
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb
  begin
    wr_ctl = 1'b0;
    wr_rll = 1'b0;
    wr_rlh = 1'b0;
    wr_cl = 1'b0;
    wr_ch = 1'b0;
    if (SFR_WR && SFR_ADDR == ADDR_CONTROL)
      wr_ctl = 1'b1;
    else if (SFR_WR && SFR_ADDR == ADDR_RELOAD_LOW)
      wr_rll = 1'b1;
    else if (SFR_WR && SFR_ADDR == ADDR_RELOAD_HIGH)
      wr_rlh = 1'b1;
    else if (SFR_WR && SFR_ADDR == ADDR_COUNT_LOW)
      wr_cl = 1'b1;
    else if (SFR_WR && SFR_ADDR == ADDR_COUNT_HIGH)
      wr_ch = 1'b1;
  end

  always_comb
  begin
    ctl_view = 8'h00;
    ctl_view[BIT_HIGH_OVF] = st_r.high_overflow_flag;
    ctl_view[BIT_LOW_OVF] = st_r.low_overflow_flag;
    ctl_view[BIT_LOW_IRQ_EN] = st_r.low_byte_irq_enable;
    ctl_view[BIT_CAPTURE_EN] = st_r.lfo_capture_enable;
    ctl_view[BIT_SPLIT] = st_r.split_mode_select;
    ctl_view[BIT_RUN] = st_r.run_control;
    ctl_view[BIT_EXT_CLK] = st_r.external_clock_select;
  end

  // ************************************************************
  // Counting
  // ************************************************************
  always_comb
  begin
    st_nxt = st_r;
    set_h = 1'b0;
    set_l = 1'b0;
    low_step = bump8(st_r.count_low, st_r.reload_low);
    high_step = bump8(st_r.count_high, st_r.reload_high);
    // 16-bit low byte carries; reload applies only on full wrap
    low_chain = {low_step[8], st_r.count_low + 8'h01};
    capture = ticks.lfo_fall && st_r.lfo_capture_enable
              && TIMER_IRQ_ENABLE;

    if (!st_r.split_mode_select)
    begin
      if (st_r.run_control && tick_l) // [R1] [R13]
      begin
        set_l = low_chain[8]; // [R4]
        if (low_chain[8])
        begin
          if (high_step[8])
          begin
            st_nxt.count_low = st_r.reload_low; // [R2]
            st_nxt.count_high = st_r.reload_high; // [R2]
            set_h = 1'b1; // [R2]
          end
          else
          begin
            st_nxt.count_low = low_chain[7:0];
            st_nxt.count_high = st_r.count_high + 8'h01; // [R13]
          end
        end
        else
        begin
          st_nxt.count_low = low_chain[7:0]; // [R13]
        end
      end
    end
    else
    begin
      // Low byte free-runs regardless of run control
      if (tick_l) // [R6]
      begin
        st_nxt.count_low = low_step[7:0]; // [R5] [R13]
        set_l = low_step[8]; // [R9]
      end
      if (st_r.run_control && tick_h) // [R6]
      begin
        st_nxt.count_high = high_step[7:0]; // [R5] [R13]
        set_h = high_step[8]; // [R9]
      end
    end

    // Software count writes win over a tick in the same cycle
    if (wr_cl)
      st_nxt.count_low = SFR_WDATA;
    if (wr_ch)
      st_nxt.count_high = SFR_WDATA;

    if (wr_rll)
      st_nxt.reload_low = SFR_WDATA;
    if (wr_rlh)
      st_nxt.reload_high = SFR_WDATA;
    // Capture beats a reload write landing on the same edge
    if (capture)
    begin
      st_nxt.reload_low = st_r.count_low; // [R12]
      st_nxt.reload_high = st_r.count_high; // [R12]
    end

    if (wr_ctl)
    begin
      st_nxt.low_byte_irq_enable = SFR_WDATA[BIT_LOW_IRQ_EN];
      st_nxt.lfo_capture_enable = SFR_WDATA[BIT_CAPTURE_EN];
      st_nxt.split_mode_select = SFR_WDATA[BIT_SPLIT]; // [R1]
      st_nxt.run_control = SFR_WDATA[BIT_RUN];
      st_nxt.external_clock_select = SFR_WDATA[BIT_EXT_CLK];
    end
    // Set wins over a clearing write so no wrap is lost
    st_nxt.high_overflow_flag = (wr_ctl ? SFR_WDATA[BIT_HIGH_OVF]
                                 : st_r.high_overflow_flag) | set_h; // [R11]
    st_nxt.low_overflow_flag = (wr_ctl ? SFR_WDATA[BIT_LOW_OVF]
                                : st_r.low_overflow_flag) | set_l; // [R11]
    st_nxt.capture_pend = (wr_ctl ? 1'b0 : st_r.capture_pend) | capture;

    // Read data is registered: valid the cycle after the strobe
    if (SFR_RD && SFR_ADDR == ADDR_CONTROL)
      st_nxt.rdata = ctl_view;
    else if (SFR_RD && SFR_ADDR == ADDR_RELOAD_LOW)
      st_nxt.rdata = st_r.reload_low;
    else if (SFR_RD && SFR_ADDR == ADDR_RELOAD_HIGH)
      st_nxt.rdata = st_r.reload_high;
    else if (SFR_RD && SFR_ADDR == ADDR_COUNT_LOW)
      st_nxt.rdata = st_r.count_low;
    else if (SFR_RD && SFR_ADDR == ADDR_COUNT_HIGH)
      st_nxt.rdata = st_r.count_high;
    else if (SFR_RD)
      st_nxt.rdata = RESET_RDATA;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_r.high_overflow_flag <= 1'b0;
      st_r.low_overflow_flag <= 1'b0;
      st_r.low_byte_irq_enable <= 1'b0;
      st_r.lfo_capture_enable <= 1'b0;
      st_r.split_mode_select <= 1'b0;
      st_r.run_control <= 1'b0;
      st_r.external_clock_select <= 1'b0;
      st_r.capture_pend <= 1'b0;
      st_r.reload_low <= RESET_RELOAD;
      st_r.reload_high <= RESET_RELOAD;
      st_r.count_low <= RESET_COUNT;
      st_r.count_high <= RESET_COUNT;
      st_r.rdata <= RESET_RDATA;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign SFR_RDATA = st_r.rdata;
  // Low flag adds a source only with its enable; high always counts
  assign IRQ = TIMER_IRQ_ENABLE & (st_r.high_overflow_flag
               | (st_r.low_byte_irq_enable & st_r.low_overflow_flag)
               | st_r.capture_pend); // [R3] [R4] [R10] [R12]

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  logic quiet;
  assign quiet = !SFR_WR && !capture;

  sequence s_full_wrap;
    !st_r.split_mode_select && st_r.run_control && tick_l
    && st_r.count_low == BYTE_MAX && st_r.count_high == BYTE_MAX;
  endsequence

  a_wrap_reload: assert property (s_full_wrap and quiet |=> // [R2]
    st_r.count_low == $past(st_r.reload_low)
    && st_r.count_high == $past(st_r.reload_high)
    && st_r.high_overflow_flag)
    else $error("16-bit wrap did not reload and flag");

  a_irq_high: assert property ((s_full_wrap and TIMER_IRQ_ENABLE // [R3]
    && !SFR_WR) ##1 TIMER_IRQ_ENABLE |-> IRQ)
    else $error("no interrupt on 16-bit overflow");

  a_irq_low16: assert property (!st_r.split_mode_select // [R4]
    && st_r.run_control && tick_l && st_r.count_low == BYTE_MAX
    && st_r.low_byte_irq_enable && !SFR_WR && TIMER_IRQ_ENABLE
    ##1 TIMER_IRQ_ENABLE |-> IRQ)
    else $error("no interrupt on low byte wrap");

  a_split_low_free: assert property (st_r.split_mode_select // [R6]
    && !st_r.run_control && tick_l && st_r.count_low != BYTE_MAX
    && quiet |=> st_r.count_low == $past(st_r.count_low) + 8'h01
    && $stable(st_r.count_high))
    else $error("split low byte not free running");

  a_split_high_wrap: assert property (st_r.split_mode_select // [R5] [R9]
    && st_r.run_control && tick_h && st_r.count_high == BYTE_MAX
    && quiet |=> st_r.count_high == $past(st_r.reload_high)
    && st_r.high_overflow_flag)
    else $error("split high byte wrap wrong");

  a_split_low_irq: assert property (st_r.split_mode_select // [R10]
    && st_r.low_overflow_flag && st_r.low_byte_irq_enable
    && TIMER_IRQ_ENABLE |-> IRQ)
    else $error("split low overflow interrupt missing");

  a_flag_sticky: assert property ( // [R11]
    (st_r.high_overflow_flag && !wr_ctl |=> st_r.high_overflow_flag)
    and (st_r.low_overflow_flag && !wr_ctl |=> st_r.low_overflow_flag))
    else $error("overflow flag cleared by hardware");

  a_capture_copy: assert property (capture |=> // [R12]
    {st_r.reload_high, st_r.reload_low}
    == {$past(st_r.count_high), $past(st_r.count_low)})
    else $error("capture did not copy count");

  a_stopped_hold: assert property (!st_r.split_mode_select // [R1] [R13]
    && !st_r.run_control && quiet |=> $stable(st_r.count_low)
    && $stable(st_r.count_high))
    else $error("stopped 16-bit counter moved");

endmodule

/* bench/sat_cpu_model.sv */
`timescale 1ns/1ps
module sat_cpu_model
(
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end

  // ************************************************************
  // Register access, one strobe cycle each
  // ************************************************************
  // Flags are only ever cleared from here
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    // Released lines carry junk so stale values never pass
    sfr_addr = ~addr;
    sfr_wdata = ~data;
  endtask

  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    sfr_addr = addr;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    sfr_addr = ~addr;
    data = sfr_rdata;
  endtask
endmodule

/* bench/sat_timer_tb_top.sv */
`timescale 1ns/1ps
module sat_timer_tb_top;
  import sat_pkg::*;
  logic clk;
  logic resetn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic ext;
  logic lfo;
  logic hi_sel;
  logic lo_sel;
  logic irq_en;
  logic irq;
  int err_count;
  int n_checks;

  sat_timer u_sat_timer (
    .CLK(clk), .RESETN(resetn), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .EXT_CLK_DIV8(ext),
    .LFO_OUT(lfo), .HIGH_BYTE_CLOCK_SELECT(hi_sel),
    .LOW_BYTE_CLOCK_SELECT(lo_sel), .TIMER_IRQ_ENABLE(irq_en), .IRQ(irq)
  );

  sat_cpu_model u_sat_cpu_model (
    .clk(clk), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_rdata(rdata)
  );

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    ext = 1'b0;
    lfo = 1'b0;
    hi_sel = 1'b1;
    lo_sel = 1'b1;
    irq_en = 1'b1;
    err_count = 0;
    n_checks = 0;
  end

  always #5 clk = ~clk;

  // ************************************************************
  // Shared helpers
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_sat_cpu_model.sfr_write(a, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] v;
    u_sat_cpu_model.sfr_read(a, v);
    check(what, v & mask, exp);
  endtask

  task automatic wait_irq();
    int i;
    for (i = 0; i < 300 && irq !== 1'b1; i++)
      @(negedge clk);
    if (irq !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] irq wait expected 1 seen %b", irq);
      test_done();
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rd_chk("control", ADDR_CONTROL, 8'h00, 8'hff);
    rd_chk("reload_low", ADDR_RELOAD_LOW, 8'h00, 8'hff);
    rd_chk("reload_high", ADDR_RELOAD_HIGH, 8'h00, 8'hff);
    rd_chk("count_low", ADDR_COUNT_LOW, 8'h00, 8'hff);
    rd_chk("count_high", ADDR_COUNT_HIGH, 8'h00, 8'hff);
    rd_chk("unmapped", 8'hc9, 8'h00, 8'hff);
    check("irq", {7'h00, irq}, 8'h00);
  endtask

  task automatic t_wrap16();
    wr_reg(ADDR_RELOAD_LOW, 8'h34);
    wr_reg(ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_COUNT_HIGH, 8'hff);
    wr_reg(ADDR_CONTROL, 8'h24);
    wait_irq();
    wr_reg(ADDR_CONTROL, 8'he0);
    rd_chk("flags_16", ADDR_CONTROL, 8'he0, 8'hff);
    rd_chk("reloaded_hi", ADDR_COUNT_HIGH, 8'h12, 8'hff);
    @(negedge clk);
    irq_en = 1'b0;
    @(negedge clk);
    check("irq_gated", {7'h00, irq}, 8'h00);
    irq_en = 1'b1;
    repeat (20) @(negedge clk);
    rd_chk("flags_kept", ADDR_CONTROL, 8'he0, 8'hff);
    check("irq_kept", {7'h00, irq}, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h00);
    check("irq_clr", {7'h00, irq}, 8'h00);
  endtask

  task automatic t_div12();
    logic [7:0] v;
    hi_sel = 1'b0;
    lo_sel = 1'b0;
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h04);
    repeat (120) @(negedge clk);
    wr_reg(ADDR_CONTROL, 8'h00);
    u_sat_cpu_model.sfr_read(ADDR_COUNT_LOW, v);
    check("div12_cnt", {7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
  endtask

  task automatic t_ext();
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h05);
    repeat (5)
    begin
      @(negedge clk);
      ext = 1'b1;
      repeat (4) @(negedge clk);
      ext = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    wr_reg(ADDR_CONTROL, 8'h00);
    rd_chk("ext_cnt", ADDR_COUNT_LOW, 8'h05, 8'hff);
    rd_chk("ext_cnt_hi", ADDR_COUNT_HIGH, 8'h00, 8'hff);
  endtask

  task automatic t_split();
    hi_sel = 1'b1;
    lo_sel = 1'b1;
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_RELOAD_LOW, 8'hf0);
    wr_reg(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_CONTROL, 8'h28);
    wait_irq();
    rd_chk("split_lflag", ADDR_CONTROL, 8'h68, 8'hff);
    rd_chk("split_hi_idle", ADDR_COUNT_HIGH, 8'h00, 8'hff);
    rd_chk("split_lo_rl", ADDR_COUNT_LOW, 8'hf0, 8'hf0);
    // Low byte frozen on a still external clock
    @(negedge clk);
    lo_sel = 1'b0;
    wr_reg(ADDR_CONTROL, 8'h09);
    check("irq_off", {7'h00, irq}, 8'h00);
    wr_reg(ADDR_RELOAD_HIGH, 8'h77);
    wr_reg(ADDR_COUNT_HIGH, 8'hfe);
    wr_reg(ADDR_CONTROL, 8'h0d);
    wait_irq();
    rd_chk("split_hflag", ADDR_CONTROL, 8'h8d, 8'hff);
    rd_chk("split_hi_rl", ADDR_COUNT_HIGH, 8'h70, 8'hf0);
    wr_reg(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_capture();
    wr_reg(ADDR_COUNT_LOW, 8'h5a);
    wr_reg(ADDR_COUNT_HIGH, 8'ha5);
    wr_reg(ADDR_CONTROL, 8'h10);
    @(negedge clk);
    lfo = 1'b1;
    repeat (8) @(negedge clk);
    lfo = 1'b0;
    wait_irq();
    rd_chk("cap_low", ADDR_RELOAD_LOW, 8'h5a, 8'hff);
    rd_chk("cap_high", ADDR_RELOAD_HIGH, 8'ha5, 8'hff);
    wr_reg(ADDR_CONTROL, 8'h00);
    check("cap_clr", {7'h00, irq}, 8'h00);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_wrap16();
    t_div12();
    t_ext();
    t_split();
    t_capture();
    test_done();
  end
endmodule
